//--- sro_pkg.sv
// constants for the serial receiver with overrun and address detection
// assumes an apb register bus with 32-bit data and word-aligned registers
package sro_pkg;
   // register byte offsets
   localparam logic [7:0] SRO_CTRL_OFS   = 8'h00;
   localparam logic [7:0] SRO_STAT_OFS   = 8'h04;
   localparam logic [7:0] SRO_RXDAT_OFS  = 8'h08;
   localparam logic [7:0] SRO_TXDAT_OFS  = 8'h0C;
   localparam logic [7:0] SRO_BAUD_OFS   = 8'h10;
   // control field positions
   localparam int SRO_C_PORT_EN   = 0;   // serial_port_enable
   localparam int SRO_C_CONT_RX   = 1;   // continuous_receive_enable
   localparam int SRO_C_NINE_RX   = 2;   // nine_bit_receive_select
   localparam int SRO_C_ADDR      = 3;   // address_detect_enable
   localparam int SRO_C_SINGLE_RX = 4;   // single_receive_enable
   localparam int SRO_C_TX_EN     = 5;   // transmit_enable
   localparam int SRO_C_NINE_TX   = 6;   // nine_bit_transmit_select
   localparam int SRO_C_TX_NINTH  = 7;   // transmit_ninth_bit
   localparam int SRO_C_MCLK_SRC  = 8;   // master_clock_source_select
   localparam int SRO_C_SYNC      = 9;   // clocked-link mode select
   localparam int SRO_C_HI_SPEED  = 10;  // baud_high_speed_select
   localparam int SRO_C_B16   = 11;  // baud_sixteen_bit_select
   localparam int SRO_CTRL_W  = 12;
   localparam logic [SRO_CTRL_W-1:0] SRO_CTRL_RST = 12'h000;
   localparam logic [15:0] SRO_BAUD_RST = 16'h0000;
   // status field positions
   localparam int SRO_S_OVR   = 0;
   localparam int SRO_S_RX_NINTH = 1;
   localparam int SRO_S_PEND  = 2;
   localparam int SRO_S_TXBSY = 3;
   localparam int SRO_S_CNT   = 4;
   localparam int SRO_RX_DEPTH = 2;
   localparam logic [3:0] SRO_BITS8 = 4'h8;
   localparam logic [3:0] SRO_BITS9 = 4'h9;
   typedef enum logic [1:0] {
      SRO_RX_IDLE = 2'b00,
      SRO_RX_DATA = 2'b01,
      SRO_RX_STOP = 2'b10
   } sro_rx_e;
   typedef enum logic [0:0] {
      SRO_TX_IDLE  = 1'b0,
      SRO_TX_SHIFT = 1'b1
   } sro_tx_e;
endpackage : sro_pkg

//--- sro_rx_top.sv
// serial transceiver: two-deep receive fifo, overrun, nine-bit and address detection,
// plus a synchronous master transmitter. assumes apb master on clk_i and a link clock
// and data pin from outside, sampled by clk_i.
//
// Added by the designer: the register offsets and register access over APB.
`timescale 1ns/1ps
// Contract
// - receive fifo holds two characters; a third complete one flags overrun (the flag is set only while continuous receive is on).
// - overrun sets the overrun error flag in the status register.
// - during overrun, held characters stay readable; no new characters accepted.
// - clearing continuous receive or port enable clears the overrun flag.
// - nine-bit select makes the receiver shift nine bits per character.
// - receive ninth bit shows bit nine of the oldest unread character.
// - address-detect enable puts the receiver into address filtering mode.
// - in address mode only characters with ninth bit one enter the fifo.
// - writing transmit data starts a synchronous transmission once set up.
// - receive pending is set while receiver enabled and fifo not empty.
// - each receive data read removes the oldest character from the fifo.
module sro_rx_top
   import sro_pkg::*;
#(
   parameter int RX_DEPTH = SRO_RX_DEPTH  // receive fifo depth
) (
   input  wire logic        clk_i,           // system clock, 50 MHz
   input  wire logic        sys_rst_i,       // async reset, active high
   input  wire logic        psel,            // apb select
   input  wire logic        penable,         // apb enable
   input  wire logic        pwrite,          // apb direction
   input  wire logic [7:0]  paddr,           // apb byte address
   input  wire logic [31:0] pwdata,          // apb write data
   output logic [31:0]      prdata,          // apb read data
   output logic             pready,          // apb ready
   output logic             pslverr,         // apb error on unmapped address
   input  wire logic        link_clk_i,      // link clock pin input
   input  wire logic        link_dat_i,      // link data pin input
   output logic             link_clk_o,      // link clock pin output
   output logic             link_clk_oe_n_o, // link clock drive, low drives
   output logic             link_dat_o,      // link data pin output
   output logic             link_dat_oe_n_o  // link data drive, low drives
);
   // the fifo indexing below serves exactly two entries
   if (RX_DEPTH != SRO_RX_DEPTH) begin : g_bad_depth
      $error("sro_rx_top: fifo depth must be two");
   end

   logic [SRO_CTRL_W-1:0] ctrl_q;
   logic [15:0]           baud_q;
   logic [31:0]           prdata_q;
   logic [8:0]            fifo_q [RX_DEPTH];
   logic                  head_q;
   logic [1:0]            cnt_q;
   logic                  ovr_q;
   sro_rx_e               rx_st_q;
   logic [3:0]            rx_bit_q;
   logic [8:0]            rx_sr_q;
   logic [2:0]            lclk_q;
   logic [1:0]            ldat_q;
   sro_tx_e               tx_st_q;
   logic [15:0]           div_q;
   logic [3:0]            tx_bit_q;
   logic [8:0]            tx_sr_q;
   logic                  tx_clk_q;
   logic                  tx_dat_q;

   wire port_en  = ctrl_q[SRO_C_PORT_EN];
   wire cont_rx  = ctrl_q[SRO_C_CONT_RX];
   wire nine_rx  = ctrl_q[SRO_C_NINE_RX];
   wire addr_det = ctrl_q[SRO_C_ADDR];
   wire rx_en    = port_en & (cont_rx | ctrl_q[SRO_C_SINGLE_RX]);
   wire wr_acc = psel & penable & pwrite;
   wire rd_acc = psel & penable & ~pwrite;
   wire mapped = (paddr == SRO_CTRL_OFS) | (paddr == SRO_STAT_OFS) |
                 (paddr == SRO_RXDAT_OFS) | (paddr == SRO_TXDAT_OFS) |
                 (paddr == SRO_BAUD_OFS);
   wire lrise  = lclk_q[1] & ~lclk_q[2];
   wire [3:0] nbits = nine_rx ? SRO_BITS9 : SRO_BITS8;
   wire [8:0] rx_char = nine_rx ? rx_sr_q : {1'b0, rx_sr_q[7:0]};
   wire rx_done = (rx_st_q == SRO_RX_STOP) & lrise;
   wire keep    = ~addr_det | rx_char[8];
   wire full    = (cnt_q == 2'(RX_DEPTH));
   wire pop     = rd_acc & (paddr == SRO_RXDAT_OFS) & (cnt_q != 2'h0);
   wire push    = rx_done & keep & ~full & ~ovr_q;
   wire ovr_ev  = rx_done & keep & full;
   wire [8:0] head_char = fifo_q[head_q];
   wire pend    = rx_en & (cnt_q != 2'h0);
   wire tx_go   = wr_acc & (paddr == SRO_TXDAT_OFS) & port_en & ctrl_q[SRO_C_TX_EN] &
                  (tx_st_q == SRO_TX_IDLE);
   wire [15:0] div_lim = ctrl_q[SRO_C_B16] ? baud_q : {8'h00, baud_q[7:0]};
   wire tick    = (div_q == div_lim);
   wire master  = port_en & ctrl_q[SRO_C_SYNC] & ctrl_q[SRO_C_MCLK_SRC] & ctrl_q[SRO_C_TX_EN];

   assign pready  = 1'b1;
   assign pslverr = psel & penable & ~mapped;
   assign prdata  = prdata_q;

   // apb register writes
   always_ff @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         ctrl_q <= SRO_CTRL_RST;
         baud_q <= SRO_BAUD_RST;
      end else if (wr_acc) begin
         if (paddr == SRO_CTRL_OFS) ctrl_q <= pwdata[SRO_CTRL_W-1:0];
         if (paddr == SRO_BAUD_OFS) baud_q <= pwdata[15:0];
      end
   end

   // read data captured in the setup cycle, held through the access cycle
   always_ff @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         prdata_q <= 32'h0000_0000;
      end else if (psel & ~penable) begin
         prdata_q <= 32'h0000_0000;
         case (paddr)
            SRO_CTRL_OFS:  prdata_q[SRO_CTRL_W-1:0] <= ctrl_q;
            SRO_STAT_OFS: begin
               prdata_q[SRO_S_OVR]   <= ovr_q;
               prdata_q[SRO_S_RX_NINTH] <= head_char[8];
               prdata_q[SRO_S_PEND]  <= pend;
               prdata_q[SRO_S_TXBSY] <= (tx_st_q == SRO_TX_SHIFT);
               prdata_q[SRO_S_CNT+1:SRO_S_CNT] <= cnt_q;
            end
            SRO_RXDAT_OFS: prdata_q[7:0] <= head_char[7:0];
            SRO_BAUD_OFS:  prdata_q[15:0] <= baud_q;
            default:       prdata_q <= 32'h0000_0000;
         endcase
      end
   end

   // pin synchronisers; only the second stage and later are read
   always_ff @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         lclk_q <= 3'h0;
         ldat_q <= 2'h3;
      end else begin
         lclk_q <= {lclk_q[1:0], link_clk_i};
         ldat_q <= {ldat_q[0], link_dat_i};
      end
   end

   // receiver: start bit, 8 or 9 data bits lsb first, stop bit, one per link clock rise
   always_ff @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         rx_st_q  <= SRO_RX_IDLE;
         rx_bit_q <= 4'h0;
         rx_sr_q  <= 9'h000;
      end else if (~rx_en | ovr_q) begin
         rx_st_q  <= SRO_RX_IDLE;
         rx_bit_q <= 4'h0;
      end else if (lrise) begin
         case (rx_st_q)
            SRO_RX_IDLE: begin
               if (~ldat_q[1]) rx_st_q <= SRO_RX_DATA;
               rx_bit_q <= 4'h0;
            end
            SRO_RX_DATA: begin
               rx_sr_q[rx_bit_q] <= ldat_q[1];
               rx_bit_q <= rx_bit_q + 4'h1;
               if (rx_bit_q == nbits - 4'h1) rx_st_q <= SRO_RX_STOP;
            end
            SRO_RX_STOP: rx_st_q <= SRO_RX_IDLE;
            default:     rx_st_q <= SRO_RX_IDLE;
         endcase
      end
   end

   // two-deep fifo; port disable empties it
   always_ff @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         head_q <= 1'b0;
         cnt_q  <= 2'h0;
         for (int i = 0; i < RX_DEPTH; i++) fifo_q[i] <= 9'h000;
      end else if (~port_en) begin
         // port disable is a module reset: no stale ninth bit survives it
         head_q <= 1'b0;
         cnt_q  <= 2'h0;
         for (int i = 0; i < RX_DEPTH; i++) fifo_q[i] <= 9'h000;
      end else begin
         if (push) fifo_q[head_q ^ cnt_q[0]] <= rx_char;
         if (pop) head_q <= ~head_q;
         cnt_q <= cnt_q + 2'(push) - 2'(pop);
      end
   end

   // overrun flag; cleared only while the receiver cannot set it
   always_ff @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) ovr_q <= 1'b0;
      else if (~port_en | ~cont_rx) ovr_q <= 1'b0;
      else if (ovr_ev) ovr_q <= 1'b1;
   end

   // synchronous master transmitter, clock from the baud divider
   always_ff @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         tx_st_q  <= SRO_TX_IDLE;
         div_q    <= 16'h0000;
         tx_bit_q <= 4'h0;
         tx_sr_q  <= 9'h000;
         tx_clk_q <= 1'b0;
         tx_dat_q <= 1'b0;
      end else if (~port_en) begin
         tx_st_q  <= SRO_TX_IDLE;
         div_q    <= 16'h0000;
         tx_clk_q <= 1'b0;
      end else if (tx_go) begin
         tx_st_q  <= SRO_TX_SHIFT;
         div_q    <= 16'h0000;
         tx_bit_q <= 4'h0;
         tx_sr_q  <= {ctrl_q[SRO_C_TX_NINTH], pwdata[7:0]};
         tx_dat_q <= pwdata[0];
         tx_clk_q <= 1'b0;
      end else if (tx_st_q == SRO_TX_SHIFT) begin
         div_q <= tick ? 16'h0000 : div_q + 16'h0001;
         if (tick) begin
            tx_clk_q <= ~tx_clk_q;
            if (tx_clk_q) begin
               tx_bit_q <= tx_bit_q + 4'h1;
               if (tx_bit_q == (ctrl_q[SRO_C_NINE_TX] ? SRO_BITS9 : SRO_BITS8) - 4'h1)
                  tx_st_q <= SRO_TX_IDLE;
               else
                  tx_dat_q <= tx_sr_q[tx_bit_q + 4'h1];
            end
         end
      end
   end

   assign link_clk_o      = tx_clk_q;
   assign link_clk_oe_n_o = ~master;
   assign link_dat_o      = tx_dat_q;
   assign link_dat_oe_n_o = ~(master & (tx_st_q == SRO_TX_SHIFT));

   AST_FIFO_MAX: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      cnt_q <= 2'(RX_DEPTH)) else $error("fifo count above two");
   AST_OVR_SET: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      ovr_ev && port_en && cont_rx |=> ovr_q) else $error("overrun not flagged");
   AST_OVR_BLOCK: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      ovr_q |-> !push && (rx_st_q == SRO_RX_IDLE)) else $error("receive during overrun");
   AST_OVR_CLR: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      !cont_rx |=> !ovr_q) else $error("overrun not cleared");
   AST_NINE: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      $rose(rx_st_q == SRO_RX_STOP) |-> rx_bit_q == nbits) else $error("wrong bit count");
   AST_NINTH: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      psel && !penable && paddr == SRO_STAT_OFS |=>
      prdata[SRO_S_RX_NINTH] == $past(head_char[8]))
      else $error("ninth bit not from head");
   AST_ADDR: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      push && addr_det |-> rx_char[8]) else $error("non-address char accepted");
   AST_PEND: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      psel && !penable && paddr == SRO_STAT_OFS && rx_en && cnt_q != 2'h0 |=>
      prdata[SRO_S_PEND]) else $error("pending lost");
   AST_POP: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      pop && !push && port_en |=> cnt_q == $past(cnt_q) - 2'h1 && head_q != $past(head_q))
      else $error("read did not pop");
   AST_KEEP: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      ovr_ev && !pop && port_en |=>
      fifo_q[0] == $past(fifo_q[0]) && fifo_q[1] == $past(fifo_q[1]))
      else $error("overrun overwrote fifo");
   AST_TXGO: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      tx_go |=> tx_st_q == SRO_TX_SHIFT && !link_dat_oe_n_o == master)
      else $error("transmit not started");
   COV_OVR:  cover property (@(posedge clk_i) disable iff (sys_rst_i) ovr_ev);
   COV_FULL: cover property (@(posedge clk_i) disable iff (sys_rst_i) push ##[1:400] full);
   COV_DROP: cover property (@(posedge clk_i) disable iff (sys_rst_i) rx_done && !keep);
   COV_TX:   cover property (@(posedge clk_i) disable iff (sys_rst_i) tx_go);
endmodule : sro_rx_top

//--- sro_node_model.sv
// remote serial node: frames characters onto the link clock and data lines
// assumes the receiver samples data on rising link clock edges
`timescale 1ns/1ps
module sro_node_model (
   output logic clk_o,  // link clock, still between frames
   output logic dat_o   // link data, pulled high when idle
);
   initial begin
      clk_o = 1'b0;
      dat_o = 1'b1;
   end
   // start bit, nb data bits lsb first, stop bit; bit time 160 ns
   task automatic send(input logic [8:0] ch, input int nb);
      logic [10:0] fr;
      fr = (nb == 9) ? {1'b1, ch, 1'b0} : {2'b11, ch[7:0], 1'b0};
      #7;
      for (int i = 0; i < nb + 2; i++) begin
         dat_o = fr[i];
         #80 clk_o = 1'b1;
         #80 clk_o = 1'b0;
      end
      dat_o = 1'b1;
   endtask : send
endmodule : sro_node_model

//--- sro_rx_top_bench.sv
// self-checking bench: register access, receive overrun, nine-bit and address
// detection, synchronous master transmit; link pins resolved from all drivers
`timescale 1ns/1ps
module sro_rx_top_bench
   import sro_pkg::*;
;
   localparam logic [31:0] EN_PORT = 32'h1 << SRO_C_PORT_EN;
   localparam logic [31:0] EN_RX   = 32'h1 << SRO_C_CONT_RX;
   localparam logic [31:0] SEL9    = 32'h1 << SRO_C_NINE_RX;
   localparam logic [31:0] ADET    = 32'h1 << SRO_C_ADDR;
   localparam logic [31:0] TX_ON   = 32'h1 << SRO_C_TX_EN;
   localparam logic [31:0] MCLK    = 32'h1 << SRO_C_MCLK_SRC;
   localparam logic [31:0] SYNCM   = 32'h1 << SRO_C_SYNC;
   logic        clk_i, sys_rst_i, psel, penable, pwrite, pready, pslverr, err;
   logic [7:0]  paddr, got;
   logic [31:0] pwdata, prdata, rd;
   logic        link_clk_o, link_clk_oe_n_o, link_dat_o, link_dat_oe_n_o;
   logic        node_clk, node_dat;
   wire         link_clk_i = link_clk_oe_n_o ? node_clk : link_clk_o;
   wire         link_dat_i = link_dat_oe_n_o ? node_dat : link_dat_o;
   int          failures, n_compared;

   sro_rx_top uut (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .link_clk_i(link_clk_i), .link_dat_i(link_dat_i),
      .link_clk_o(link_clk_o), .link_clk_oe_n_o(link_clk_oe_n_o),
      .link_dat_o(link_dat_o), .link_dat_oe_n_o(link_dat_oe_n_o));
   sro_node_model node (.clk_o(node_clk), .dat_o(node_dat));

   initial begin
      clk_i = 1'b0;
      forever #10 clk_i = ~clk_i;
   end

   function automatic logic [31:0] st(logic ovr, logic r9, logic pend, logic [1:0] cnt);
      return {26'h0, cnt, 1'b0, pend, r9, ovr};
   endfunction : st

   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp) begin
         failures++;
         $display("unexpected %s: expected %h seen %h", what, exp, seen);
      end
   endtask : check

   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk_i);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk_i);
      penable <= 1'b1;
      @(posedge clk_i);
      while (pready !== 1'b1) @(posedge clk_i);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   task automatic expect_reg(input string what, input logic [7:0] a, input logic [31:0] exp);
      apb(1'b0, a, 32'h0);
      check(what, rd, exp);
   endtask : expect_reg

   task automatic rx_wait();
      repeat (8) @(posedge clk_i);
   endtask : rx_wait

   task automatic t_reset();
      expect_reg("ctrl", SRO_CTRL_OFS, 32'h0);
      expect_reg("status", SRO_STAT_OFS, 32'h0);
      expect_reg("baud", SRO_BAUD_OFS, 32'h0);
      apb(1'b0, 8'h14, 32'h0);
      check("slverr", {31'h0, err}, 32'h1);
      check("unmapped", rd, 32'h0);
   endtask : t_reset

   task automatic t_overrun();
      for (int k = 0; k < 2; k++) begin
         apb(1'b1, SRO_CTRL_OFS, EN_PORT | EN_RX);
         for (int c = 0; c < 3; c++) begin
            node.send(9'h011 + 9'(c), 8);
            rx_wait();
         end
         expect_reg("ovr_stat", SRO_STAT_OFS, st(1'b1, 1'b0, 1'b1, 2'h2));
         node.send(9'h044, 8);
         rx_wait();
         expect_reg("held_stat", SRO_STAT_OFS, st(1'b1, 1'b0, 1'b1, 2'h2));
         expect_reg("first", SRO_RXDAT_OFS, 32'h11);
         expect_reg("second", SRO_RXDAT_OFS, 32'h12);
         expect_reg("empty_stat", SRO_STAT_OFS, st(1'b1, 1'b0, 1'b0, 2'h0));
         apb(1'b1, SRO_CTRL_OFS, (k == 0) ? EN_PORT : 32'h0);
         expect_reg("cleared", SRO_STAT_OFS, 32'h0);
      end
   endtask : t_overrun

   task automatic t_addr();
      apb(1'b1, SRO_CTRL_OFS, EN_PORT | EN_RX | SEL9 | ADET);
      node.send(9'h033, 9);
      rx_wait();
      expect_reg("skip_data", SRO_STAT_OFS, 32'h0);
      node.send(9'h1C4, 9);
      rx_wait();
      expect_reg("addr_stat", SRO_STAT_OFS, st(1'b0, 1'b1, 1'b1, 2'h1));
      apb(1'b1, SRO_CTRL_OFS, EN_PORT | EN_RX | SEL9);
      node.send(9'h012, 9);
      rx_wait();
      expect_reg("two_stat", SRO_STAT_OFS, st(1'b0, 1'b1, 1'b1, 2'h2));
      expect_reg("addr_char", SRO_RXDAT_OFS, 32'hC4);
      expect_reg("next_stat", SRO_STAT_OFS, st(1'b0, 1'b0, 1'b1, 2'h1));
      expect_reg("data_char", SRO_RXDAT_OFS, 32'h12);
      apb(1'b1, SRO_CTRL_OFS, EN_PORT | EN_RX | SEL9 | ADET);
      apb(1'b1, SRO_CTRL_OFS, 32'h0);
   endtask : t_addr

   task automatic t_tx();
      apb(1'b1, SRO_BAUD_OFS, 32'h1);
      apb(1'b1, SRO_CTRL_OFS, EN_PORT | SYNCM | MCLK);
      apb(1'b1, SRO_CTRL_OFS, EN_PORT | SYNCM | MCLK | TX_ON);
      apb(1'b1, SRO_TXDAT_OFS, 32'h96);
      for (int i = 0; i < 8; i++) begin
         @(posedge link_clk_o);
         got[i] = link_dat_o;
         check("dat_drive", {31'h0, link_dat_oe_n_o}, 32'h0);
         check("clk_drive", {31'h0, link_clk_oe_n_o}, 32'h0);
      end
      check("tx_bits", {24'h0, got}, 32'h96);
      repeat (20) @(posedge clk_i);
      expect_reg("tx_done", SRO_STAT_OFS, 32'h0);
   endtask : t_tx

   task automatic final_report();
      $display("compared %0d mismatches %0d", n_compared, failures);
      if (failures == 0 && n_compared > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask : final_report

   initial begin
      #300000;
      failures++;
      final_report();
   end

   initial begin
      sys_rst_i = 1'b1;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0;
      failures = 0;
      n_compared = 0;
      repeat (6) @(posedge clk_i);
      sys_rst_i <= 1'b0;
      t_reset();
      t_overrun();
      t_addr();
      t_tx();
      final_report();
   end
endmodule : sro_rx_top_bench
